// ==== tb.sv ====
`timescale 1ns/1ps
module tb;
  logic        hclk;
  logic        hresetn;
  logic        ce;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        wide_pulse_out;
  logic        wide_pulse_oe;
  logic        narrow_pulse_out;
  logic        narrow_pulse_oe;
  logic        irq;
  logic        ext_clk_in;
  logic [2:0]  ext_div;
  int          bad_count;
  int          check_count;
  int          cyc;

  tppg_top dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .ext_clk_in(ext_clk_in),
    .wide_pulse_out(wide_pulse_out), .wide_pulse_oe(wide_pulse_oe),
    .narrow_pulse_out(narrow_pulse_out), .narrow_pulse_oe(narrow_pulse_oe), .irq(irq));

  always #5 hclk = ~hclk;

  // A free-running external count clock of eight system clocks per period.
  always @(posedge hclk) begin
    ext_div    <= ext_div + 3'h1;
    ext_clk_in <= ext_div[2];
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // The longest scenario is the narrow free-running period of 4096 cycles.
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One single transfer; the request is held until hready is seen high.
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] x;
    ahb(1'b0, a, 32'h0000_0000, x);
    check(what, x, exp);
  endtask

  function automatic logic pin(input logic nar);
    return nar ? narrow_pulse_out : wide_pulse_out;
  endfunction

  // Skips any partial period so that one whole active and inactive span is counted.
  task automatic measure(input logic nar, input int eh, input int el, input string what);
    int h;
    int l;
    h = 0;
    l = 0;
    @(negedge hclk);
    while (pin(nar) !== 1'b0) @(negedge hclk);
    while (pin(nar) !== 1'b1) @(negedge hclk);
    while (pin(nar) === 1'b1) begin
      h++;
      @(negedge hclk);
    end
    while (pin(nar) === 1'b0) begin
      l++;
      @(negedge hclk);
    end
    check({what, " active"}, h, eh);
    check({what, " inactive"}, l, el);
  endtask

  task automatic t_reset();
    rdchk(8'h00, 32'h0000_0000, "ctrl reset");
    rdchk(8'h04, 32'h0000_0000, "wide compare reset");
    rdchk(8'h08, 32'h0000_FF01, "narrow compare reset");
    rdchk(8'h10, 32'h0000_0000, "status reset");
    rdchk(8'h40, 32'h0000_0000, "unmapped read");
    @(posedge hclk);
    ce <= 1'b0;
    @(negedge hclk);
    check("ready with ce low", hreadyout, 1'b0);
    @(posedge hclk);
    ce <= 1'b1;
    $display("test reset done");
  endtask

  task automatic t_wide_ppg();
    wr(8'h04, 32'h0009_0003);
    wr(8'h00, 32'h0000_0345);
    measure(1'b0, 3, 7, "wide pulse");
    check("wide oe", wide_pulse_oe, 1'b1);
    rdchk(8'h10, 32'h0000_0003, "wide flags");
    check("irq masked", irq, 1'b0);
    wr(8'h14, 32'h0000_0001);
    wr(8'h18, 32'h0000_0001);
    for (int i = 0; i < 20 && irq !== 1'b1; i++) @(negedge hclk);
    check("irq on width match", irq, 1'b1);
    wr(8'h04, 32'h0009_0005);
    wr(8'h18, 32'h0000_0000);
    measure(1'b0, 5, 5, "wide new duty");
    $display("test wide pulse done");
  endtask

  task automatic t_stop();
    wr(8'h00, 32'h0000_0344);
    repeat (3) @(negedge hclk);
    check("stopped pin", wide_pulse_out, 1'b0);
    rdchk(8'h0C, 32'h0000_0000, "stopped count");
    wr(8'h14, 32'h0000_000F);
    rdchk(8'h10, 32'h0000_0000, "flags cleared");
    check("irq cleared", irq, 1'b0);
    wr(8'h00, 32'h0000_0048);
    repeat (5) @(negedge hclk);
    check("static level", wide_pulse_out, 1'b1);
    wr(8'h00, 32'h0000_0000);
    $display("test stop done");
  endtask

  task automatic t_narrow();
    wr(8'h08, 32'h0000_0402);
    wr(8'h00, 32'h0001_D092);
    measure(1'b1, 32, 48, "narrow pulse");
    rdchk(8'h10, 32'h0000_000C, "narrow flags");
    wr(8'h00, 32'h0001_5092);
    rdchk(8'h00, 32'h0001_D092, "illegal mode kept");
    wr(8'h08, 32'h0000_0100);
    rdchk(8'h08, 32'h0000_0402, "out of range compare");
    wr(8'h08, 32'h0000_0440);
    wr(8'h00, 32'h0001_4092);
    measure(1'b1, 1024, 3072, "narrow free run");
    wr(8'h00, 32'h0000_0000);
    $display("test narrow done");
  endtask

  task automatic t_ext();
    wr(8'h08, 32'h0000_0402);
    wr(8'h00, 32'h000F_D092);
    measure(1'b1, 16, 24, "narrow external clock");
    wr(8'h00, 32'h0000_0000);
    $display("test external clock done");
  endtask

  initial begin
    hclk        = 1'b0;
    hresetn     = 1'b0;
    ce          = 1'b1;
    hsel        = 1'b0;
    haddr       = 32'h0000_0000;
    htrans      = 2'h0;
    hwrite      = 1'b0;
    hwdata      = 32'h0000_0000;
    ext_clk_in  = 1'b0;
    ext_div     = 3'h0;
    bad_count   = 0;
    check_count = 0;
    cyc         = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_wide_ppg();
    t_stop();
    t_narrow();
    t_ext();
    print_verdict();
  end
endmodule // tb

// ==== tppg_cfg.svh ====
`ifndef TPPG_CFG_SVH
`define TPPG_CFG_SVH

`define TPPG_OFF_CTRL     8'h00
`define TPPG_OFF_CMPW     8'h04
`define TPPG_OFF_CMPN     8'h08
`define TPPG_OFF_CNT      8'h0C
`define TPPG_OFF_ISTAT    8'h10
`define TPPG_OFF_ICLR     8'h14
`define TPPG_OFF_IEN      8'h18

`define TPPG_CTRL_RST     32'h0000_0000
`define TPPG_CTRL_MASK    32'h000F_F3FF
`define TPPG_CMPW_RST     16'h0000
`define TPPG_CMPN_WID_RST 8'h01
`define TPPG_CMPN_PER_RST 8'hFF

`define TPPG_N_WID_MIN    8'h01
`define TPPG_N_PER_MIN    8'h02
`define TPPG_W_TOP        16'hFFFF
`define TPPG_N_TOP        16'h00FF

`define TPPG_NM_TGL       4'h0
`define TPPG_NM_TGL_CLR   4'h1
`define TPPG_NM_TGL_CAP   4'h2
`define TPPG_NM_TGL_BOTH  4'h3
`define TPPG_NM_PWM1      4'h4
`define TPPG_NM_PWM2      4'h8
`define TPPG_NM_PPG       4'hD

`define TPPG_PRS_16       4'h1
`define TPPG_PRS_32       4'h3
`define TPPG_PRS_64       4'h4
`define TPPG_PRS_128      4'h5
`define TPPG_PRS_256      4'h6
`define TPPG_PRS_512      4'h7
`define TPPG_PRS_EXT      4'hF

`define TPPG_IRQ_W_WID    0
`define TPPG_IRQ_W_PER    1
`define TPPG_IRQ_N_WID    2
`define TPPG_IRQ_N_PER    3

`endif

// ==== tppg_pkg.sv ====
package tppg_pkg;

  typedef enum logic [1:0] {
    K_TGL     = 2'b00,
    K_TGL_CLR = 2'b01,
    K_PWM     = 2'b10,
    K_PPG     = 2'b11
  } tppg_kind_e;

  typedef struct packed {
    logic [11:0] rsvd_hi;
    logic [3:0]  prs;
    logic [3:0]  nmode;
    logic [1:0]  rsvd_lo;
    logic [1:0]  wmode;
    logic        n_port;
    logic        w_port;
    logic        n_alv;
    logic        n_oes;
    logic        w_alv;
    logic        w_oes;
    logic        n_cen;
    logic        w_cen;
  } tppg_ctrl_s;

  typedef struct packed {
    logic [15:0] cnt;
    logic        act;
  } tppg_chan_s;

  typedef struct packed {
    tppg_chan_s c;
    logic       wm;
    logic       pm;
  } tppg_step_s;

  typedef struct packed {
    tppg_ctrl_s  ctrl;
    logic [15:0] w_wid;
    logic [15:0] w_per;
    logic [7:0]  n_wid;
    logic [7:0]  n_per;
    tppg_chan_s  w;
    tppg_chan_s  n;
    logic [8:0]  div;
    logic        ext_s1;
    logic        ext_s2;
    logic        ext_s3;
    logic [3:0]  ist;
    logic [3:0]  ien;
    logic        dp_wr;
    logic [7:0]  dp_addr;
    logic [31:0] rdata;
    logic        w_pin;
    logic        n_pin;
  } tppg_state_s;

endpackage

// ==== tppg_top.sv ====
// The implementer's own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "tppg_cfg.svh"

module tppg_top
  import tppg_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        ext_clk_in,
  output logic             wide_pulse_out,
  output logic             wide_pulse_oe,
  output logic             narrow_pulse_out,
  output logic             narrow_pulse_oe,
  output logic             irq
);

  tppg_state_s s_q;
  tppg_state_s s_d;
  tppg_step_s  ws;
  tppg_step_s  ns;
  logic        ext_edge;
  logic        ntick;
  logic [3:0]  set_ev;
  logic [3:0]  clr;
  logic        hsize_unused;

  function automatic logic presc_tick(input logic [3:0] sel, input logic [8:0] div,
                                      input logic ext);
    presc_tick = 1'b0;
    if (sel == `TPPG_PRS_16) begin
      presc_tick = &div[3:0];
    end else if (sel == `TPPG_PRS_32) begin
      presc_tick = &div[4:0];
    end else if (sel == `TPPG_PRS_64) begin
      presc_tick = &div[5:0];
    end else if (sel == `TPPG_PRS_128) begin
      presc_tick = &div[6:0];
    end else if (sel == `TPPG_PRS_256) begin
      presc_tick = &div[7:0];
    end else if (sel == `TPPG_PRS_512) begin
      presc_tick = &div[8:0];
    end else if (sel == `TPPG_PRS_EXT) begin
      presc_tick = ext;
    end
  endfunction

  function automatic logic mode_ok(input logic [3:0] m);
    mode_ok = (m == `TPPG_NM_TGL) || (m == `TPPG_NM_TGL_CLR) || (m == `TPPG_NM_TGL_CAP) ||
              (m == `TPPG_NM_TGL_BOTH) || (m == `TPPG_NM_PWM1) || (m == `TPPG_NM_PWM2) ||
              (m == `TPPG_NM_PPG);
  endfunction

  // Capture is not built, so the capture-clear settings behave as their plain counterparts.
  function automatic tppg_kind_e narrow_kind(input logic [3:0] m);
    narrow_kind = K_TGL;
    if (m == `TPPG_NM_TGL_CLR || m == `TPPG_NM_TGL_BOTH) begin
      narrow_kind = K_TGL_CLR;
    end else if (m == `TPPG_NM_PWM1 || m == `TPPG_NM_PWM2) begin
      narrow_kind = K_PWM;
    end else if (m == `TPPG_NM_PPG) begin
      narrow_kind = K_PPG;
    end
  endfunction

  // One counter step; the wide and narrow counters share it, the narrow one with top FFH.
  function automatic tppg_step_s chan_step(input tppg_chan_s c, input logic en,
                                           input logic tick, input tppg_kind_e k,
                                           input logic [15:0] wv, input logic [15:0] pv,
                                           input logic [15:0] top);
    tppg_step_s r;
    logic       clr_hit;
    r.c     = c;
    r.wm    = 1'b0;
    r.pm    = 1'b0;
    clr_hit = 1'b0;
    if (!en) begin
      r.c.cnt = 16'h0000;
      r.c.act = (k == K_PWM) || (k == K_PPG);
    end else if (tick) begin
      clr_hit = ((k == K_TGL_CLR) || (k == K_PPG)) && (c.cnt == pv);
      r.c.cnt = (clr_hit || (c.cnt == top)) ? 16'h0000 : c.cnt + 16'h0001;
      // A match is taken as the counter arrives at a value, so a width of n spans n counts.
      r.wm = (r.c.cnt == wv);
      r.pm = (r.c.cnt == pv);
      case (k)
        K_TGL, K_TGL_CLR: begin
          if (r.wm) begin
            r.c.act = ~c.act;
          end
        end
        K_PWM: begin
          if (c.cnt == top) begin
            r.c.act = 1'b1;
          end
          if (r.wm) begin
            r.c.act = 1'b0;
          end
        end
        default: begin
          if (clr_hit) begin
            r.c.act = 1'b1;
          end
          if (r.wm) begin
            r.c.act = 1'b0;
          end
        end
      endcase
    end
    chan_step = r;
  endfunction

  function automatic logic pin_level(input logic oes, input logic act, input logic en,
                                     input logic alv);
    pin_level = oes ? ((act & en) ^ alv) : alv;
  endfunction

  function automatic logic [31:0] rd_mux(input tppg_state_s s, input logic [7:0] a);
    rd_mux = 32'h0000_0000;
    if (a == `TPPG_OFF_CTRL) begin
      rd_mux = s.ctrl;
    end else if (a == `TPPG_OFF_CMPW) begin
      rd_mux = {s.w_per, s.w_wid};
    end else if (a == `TPPG_OFF_CMPN) begin
      rd_mux = {16'h0000, s.n_per, s.n_wid};
    end else if (a == `TPPG_OFF_CNT) begin
      rd_mux = {6'h00, s.n_pin, s.w_pin, s.n.cnt[7:0], s.w.cnt};
    end else if (a == `TPPG_OFF_ISTAT) begin
      rd_mux = {28'h0000000, s.ist};
    end else if (a == `TPPG_OFF_IEN) begin
      rd_mux = {28'h0000000, s.ien};
    end
  endfunction

  always_comb begin
    s_d = s_q;
    hsize_unused = |hsize;
    ext_edge = s_q.ext_s2 & ~s_q.ext_s3;
    ntick = presc_tick(s_q.ctrl.prs, s_q.div, ext_edge);
    ws = chan_step(s_q.w, s_q.ctrl.w_cen, 1'b1, tppg_kind_e'(s_q.ctrl.wmode),
                   s_q.w_wid, s_q.w_per, `TPPG_W_TOP);
    ns = chan_step(s_q.n, s_q.ctrl.n_cen, ntick, narrow_kind(s_q.ctrl.nmode),
                   {8'h00, s_q.n_wid}, {8'h00, s_q.n_per}, `TPPG_N_TOP);
    s_d.w = ws.c;
    s_d.n = ns.c;
    // Clearing the divider while stopped makes the first count clock land at a fixed place.
    s_d.div = s_q.ctrl.n_cen ? s_q.div + 9'h001 : 9'h000;
    s_d.ext_s1 = ext_clk_in;
    s_d.ext_s2 = s_q.ext_s1;
    s_d.ext_s3 = s_q.ext_s2;
    set_ev = 4'h0;
    set_ev[`TPPG_IRQ_W_WID] = ws.wm;
    set_ev[`TPPG_IRQ_W_PER] = ws.pm;
    set_ev[`TPPG_IRQ_N_WID] = ns.wm;
    set_ev[`TPPG_IRQ_N_PER] = ns.pm;
    clr = 4'h0;
    if (s_q.dp_wr) begin
      if (s_q.dp_addr == `TPPG_OFF_CTRL) begin
        s_d.ctrl = tppg_ctrl_s'(hwdata & `TPPG_CTRL_MASK);
        if (!mode_ok(hwdata[15:12])) begin
          s_d.ctrl.nmode = s_q.ctrl.nmode;
        end
      end else if (s_q.dp_addr == `TPPG_OFF_CMPW) begin
        s_d.w_wid = hwdata[15:0];
        s_d.w_per = hwdata[31:16];
      end else if (s_q.dp_addr == `TPPG_OFF_CMPN) begin
        if (hwdata[7:0] >= `TPPG_N_WID_MIN) begin
          s_d.n_wid = hwdata[7:0];
        end
        if (hwdata[15:8] >= `TPPG_N_PER_MIN) begin
          s_d.n_per = hwdata[15:8];
        end
      end else if (s_q.dp_addr == `TPPG_OFF_ICLR) begin
        clr = hwdata[3:0];
      end else if (s_q.dp_addr == `TPPG_OFF_IEN) begin
        s_d.ien = hwdata[3:0];
      end
    end
    // A match in the same cycle as its clear keeps the flag set.
    s_d.ist = (s_q.ist & ~clr) | set_ev;
    s_d.dp_wr = 1'b0;
    if (hsel && htrans[1] && hready) begin
      s_d.dp_wr = hwrite;
      s_d.dp_addr = haddr[7:0];
      if (!hwrite) begin
        s_d.rdata = rd_mux(s_q, haddr[7:0]);
      end
    end
    s_d.w_pin = pin_level(s_d.ctrl.w_oes, s_d.w.act, s_d.ctrl.w_cen, s_d.ctrl.w_alv);
    s_d.n_pin = pin_level(s_d.ctrl.n_oes, s_d.n.act, s_d.ctrl.n_cen, s_d.ctrl.n_alv);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q       <= '0;
      s_q.ctrl  <= tppg_ctrl_s'(`TPPG_CTRL_RST);
      s_q.w_wid <= `TPPG_CMPW_RST;
      s_q.w_per <= `TPPG_CMPW_RST;
      s_q.n_wid <= `TPPG_CMPN_WID_RST;
      s_q.n_per <= `TPPG_CMPN_PER_RST;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // Holding hready low while the clock enable is low keeps bus transfers from being lost.
  assign hreadyout        = ce;
  assign hresp            = 1'b0;
  assign hrdata           = s_q.rdata;
  assign irq              = |(s_q.ist & s_q.ien);
  assign wide_pulse_out   = s_q.w_pin;
  assign narrow_pulse_out = s_q.n_pin;
  assign wide_pulse_oe    = s_q.ctrl.w_port;
  assign narrow_pulse_oe  = s_q.ctrl.n_port;

  logic w_ppg;
  logic n_ppg;
  logic n_pwm;
  assign w_ppg = (s_q.ctrl.wmode == K_PPG) && s_q.ctrl.w_cen;
  assign n_ppg = (narrow_kind(s_q.ctrl.nmode) == K_PPG) && s_q.ctrl.n_cen;
  assign n_pwm = (narrow_kind(s_q.ctrl.nmode) == K_PWM) && s_q.ctrl.n_cen;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_stop_clear;
    ce && !s_q.ctrl.n_cen && !s_q.dp_wr |=> s_q.n.cnt == 16'h0000;
  endproperty
  a_stop_clear: assert property (p_stop_clear) else $error("stopped counter not cleared");

  property p_wide_period_clear;
    ce && w_ppg && !s_q.dp_wr && s_q.w.cnt == s_q.w_per && s_q.w_wid != 16'h0000
      |=> s_q.w.cnt == 16'h0000 && s_q.w.act;
  endproperty
  a_wide_period_clear: assert property (p_wide_period_clear) else $error("no clear at period");

  property p_wide_width_end;
    ce && w_ppg && !s_q.dp_wr && s_q.w.cnt != s_q.w_per && s_q.w.cnt + 16'h0001 == s_q.w_wid
      |=> !s_q.w.act && s_q.w.cnt == s_q.w_wid;
  endproperty
  a_wide_width_end: assert property (p_wide_width_end) else $error("pulse not ended");

  property p_period_turn;
    ce && n_ppg && ntick && !s_q.dp_wr && s_q.n.cnt[7:0] == s_q.n_per
      |=> s_q.n.act && s_q.n.cnt == 16'h0000;
  endproperty
  a_period_turn: assert property (p_period_turn) else $error("period match not handled");

  // The period flag leads the output turn by one count clock.
  property p_period_flag;
    ce && n_ppg && ntick && s_q.n.cnt[7:0] + 8'h01 == s_q.n_per
      |=> s_q.ist[`TPPG_IRQ_N_PER] && s_q.n.cnt[7:0] == s_q.n_per;
  endproperty
  a_period_flag: assert property (p_period_flag) else $error("period flag not set");

  property p_narrow_hold;
    ce && s_q.ctrl.n_cen && !ntick && !s_q.dp_wr |=> $stable(s_q.n.cnt);
  endproperty
  a_narrow_hold: assert property (p_narrow_hold) else $error("count without count clock");

  property p_width_flag;
    ce && s_q.ctrl.w_cen && !s_q.dp_wr && s_q.w.cnt != s_q.w_per
      && s_q.w.cnt + 16'h0001 == s_q.w_wid |=> s_q.ist[`TPPG_IRQ_W_WID];
  endproperty
  a_width_flag: assert property (p_width_flag) else $error("width flag not set");

  property p_static_pin;
    !s_q.ctrl.n_oes |-> narrow_pulse_out == s_q.ctrl.n_alv;
  endproperty
  a_static_pin: assert property (p_static_pin) else $error("static level wrong");

  property p_stopped_inactive;
    s_q.ctrl.w_oes && !s_q.ctrl.w_cen |-> wide_pulse_out == s_q.ctrl.w_alv;
  endproperty
  a_stopped_inactive: assert property (p_stopped_inactive) else $error("stopped pin active");

  property p_active_high;
    s_q.ctrl.n_oes && !s_q.ctrl.n_alv && s_q.ctrl.n_cen |-> narrow_pulse_out == s_q.n.act;
  endproperty
  a_active_high: assert property (p_active_high) else $error("active level wrong");

  property p_pwm_wrap;
    ce && n_pwm && ntick && !s_q.dp_wr && s_q.n.cnt == `TPPG_N_TOP
      |=> s_q.n.cnt == 16'h0000 && s_q.n.act;
  endproperty
  a_pwm_wrap: assert property (p_pwm_wrap) else $error("pwm wrap wrong");

  property p_n_width_end;
    ce && n_ppg && ntick && !s_q.dp_wr && s_q.n.cnt[7:0] != s_q.n_per
      && s_q.n.cnt[7:0] + 8'h01 == s_q.n_wid |=> !s_q.n.act;
  endproperty
  a_n_width_end: assert property (p_n_width_end) else $error("pulse too long");

  property p_pwm_end;
    ce && n_pwm && ntick && !s_q.dp_wr && s_q.n.cnt[7:0] + 8'h01 == s_q.n_wid |=> !s_q.n.act;
  endproperty
  a_pwm_end: assert property (p_pwm_end) else $error("pwm pulse too long");

  property p_mode_legal;
    mode_ok(s_q.ctrl.nmode);
  endproperty
  a_mode_legal: assert property (p_mode_legal) else $error("illegal mode held");

  property p_cmp_floor;
    s_q.n_per >= `TPPG_N_PER_MIN && s_q.n_wid >= `TPPG_N_WID_MIN;
  endproperty
  a_cmp_floor: assert property (p_cmp_floor) else $error("compare below range");

  property p_n_stopped;
    s_q.ctrl.n_oes && !s_q.ctrl.n_cen |-> narrow_pulse_out == s_q.ctrl.n_alv;
  endproperty
  a_n_stopped: assert property (p_n_stopped) else $error("stopped pin active");

endmodule // tppg_top
